/* File: logic/rtc_count.sv */
// Added by the designer: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
module rtc_count
#(
  parameter int HALF_CYC = rtc_count_pkg::HALF_SEC_CYC,
  parameter int TICK_CYC = rtc_count_pkg::CD_TICK_CYC
)
(
  // clock and resets
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        por_resetn,
  input  wire logic        rtc_resetn,
  // axi4-lite write
  input  wire logic [7:0]  s_awaddr,
  input  wire logic        s_awvalid,
  output logic             s_awready,
  input  wire logic [31:0] s_wdata,
  input  wire logic [3:0]  s_wstrb,
  input  wire logic        s_wvalid,
  output logic             s_wready,
  output logic [1:0]       s_bresp,
  output logic             s_bvalid,
  input  wire logic        s_bready,
  // axi4-lite read
  input  wire logic [7:0]  s_araddr,
  input  wire logic        s_arvalid,
  output logic             s_arready,
  output logic [31:0]      s_rdata,
  output logic [1:0]       s_rresp,
  output logic             s_rvalid,
  input  wire logic        s_rready,
  // pins and request
  output logic             half_second_pulse_out,
  output logic             irq
);
  import rtc_count_pkg::*;

  // ==========================================================
  // state
  logic [7:0] sec_r, min_r, hour_r, day_r, wday_r, mon_r, year_r;
  logic [7:0] al_min_r, al_hour_r, al_day_r, al_mon_r, al_year_r;
  logic [4:0] alarm_en_r;
  logic [7:0] flags_r, flags_nxt;
  logic [6:0] other_flags_r;
  logic       alarm_flag_r;
  logic       cold_start;
  logic [7:0] irq_en_r;
  logic       rtc_operate_r, rewrite_keep_counting_r, counter_recall_r;
  logic       countdown_go_r, countdown_periodic_r, countdown_active_r;
  logic [CD_WIDTH-1:0] reload_r, cd_r, cd_nxt;
  logic [31:0] half_cnt_r, tick_cnt_r;
  logic       half_r, pulse_r;
  logic [1:0] half_seen_r;
  logic       recall_busy_r;
  logic       aw_got_r, w_got_r;
  logic [7:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0]  wstrb_r;

  logic        wr_fire, rd_fire, wr_ok, half_tick, cd_tick, match, cd_under;
  logic [7:0]  wb;
  logic        go_nxt, active_nxt, al_en_rise;

  // field match with enable: disabled fields compare true
  function automatic logic fmatch(input logic en, input logic [7:0] a, input logic [7:0] b);
    fmatch = !en || (a == b);
  endfunction

  // ==========================================================
  // axi4-lite slave, one write and one read at a time
  assign s_awready = !aw_got_r && !s_bvalid;
  assign s_wready  = !w_got_r && !s_bvalid;
  assign s_arready = !s_rvalid;
  assign wr_fire   = aw_got_r && w_got_r && !s_bvalid;
  assign rd_fire   = s_arvalid && s_arready;
  assign wb        = wstrb_r[0] ? wdata_r[7:0] : RST_BYTE;
  assign wr_ok     = wr_fire && wstrb_r[0];

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_got_r <= 1'b0;
      w_got_r  <= 1'b0;
      awaddr_r <= RST_BYTE;
      wdata_r  <= '0;
      wstrb_r  <= '0;
      s_bvalid <= 1'b0;
      s_bresp  <= AXI_OKAY;
    end
    else
    begin
      if (s_awvalid && s_awready)
      begin
        aw_got_r <= 1'b1;
        awaddr_r <= s_awaddr;
      end
      if (s_wvalid && s_wready)
      begin
        w_got_r <= 1'b1;
        wdata_r <= s_wdata;
        wstrb_r <= s_wstrb;
      end
      if (wr_fire)
      begin
        aw_got_r <= 1'b0;
        w_got_r  <= 1'b0;
        s_bvalid <= 1'b1;
        s_bresp  <= (awaddr_r <= ADDR_RELOAD_HI && awaddr_r[1:0] == 2'b00) ? AXI_OKAY
                                                                           : AXI_SLVERR;
      end
      else if (s_bvalid && s_bready)
        s_bvalid <= 1'b0;
    end
  end

  // read mux; unmapped answers slverr with zero data
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_rvalid <= 1'b0;
      s_rdata  <= '0;
      s_rresp  <= AXI_OKAY;
    end
    else if (rd_fire)
    begin
      s_rvalid <= 1'b1;
      s_rresp  <= AXI_OKAY;
      unique case (s_araddr)
        ADDR_MAIN_CTRL:  s_rdata <= {24'h0, 1'b0, 2'b00, rewrite_keep_counting_r, 1'b0,
                                     countdown_active_r | rtc_operate_r, 1'b0, rtc_operate_r};
        ADDR_ALARM_EN:   s_rdata <= {27'h0, alarm_en_r};
        ADDR_IRQ_FLAGS:  s_rdata <= {24'h0, flags_r};
        ADDR_IRQ_EN:     s_rdata <= {24'h0, irq_en_r};
        ADDR_XFER_CTRL:  s_rdata <= {31'h0, counter_recall_r};
        ADDR_CD_CTRL:    s_rdata <= {29'h0, countdown_active_r, countdown_periodic_r,
                                     countdown_go_r};
        ADDR_SEC:        s_rdata <= {24'h0, sec_r};
        ADDR_MIN:        s_rdata <= {24'h0, min_r};
        ADDR_HOUR:       s_rdata <= {24'h0, hour_r};
        ADDR_DAY:        s_rdata <= {24'h0, day_r};
        ADDR_WDAY:       s_rdata <= {24'h0, wday_r};
        ADDR_MONTH:      s_rdata <= {24'h0, mon_r};
        ADDR_YEAR:       s_rdata <= {24'h0, year_r};
        ADDR_AL_MIN:     s_rdata <= {24'h0, al_min_r};
        ADDR_AL_HOUR:    s_rdata <= {24'h0, al_hour_r};
        ADDR_AL_DAY:     s_rdata <= {24'h0, al_day_r};
        ADDR_AL_MONTH:   s_rdata <= {24'h0, al_mon_r};
        ADDR_AL_YEAR:    s_rdata <= {24'h0, al_year_r};
        ADDR_RELOAD_LO:  s_rdata <= {24'h0, reload_r[7:0]};
        ADDR_RELOAD_MID: s_rdata <= {24'h0, reload_r[15:8]};
        ADDR_RELOAD_HI:  s_rdata <= {30'h0, reload_r[17:16]};
        default:
        begin
          s_rdata <= '0;
          s_rresp <= AXI_SLVERR;
        end
      endcase
    end
    else if (s_rvalid && s_rready)
      s_rvalid <= 1'b0;
  end

  // ==========================================================
  // calendar and alarm store, bcd fields; not touched by any reset
  always_ff @(posedge aclk)
  begin
    if (wr_ok)
    begin
      unique case (awaddr_r)
        ADDR_SEC:      sec_r     <= {1'b0, wb[6:0]};
        ADDR_MIN:      min_r     <= {1'b0, wb[6:0]};
        ADDR_HOUR:     hour_r    <= {2'b00, wb[5:0]};
        ADDR_DAY:      day_r     <= {2'b00, wb[5:0]};
        ADDR_WDAY:     wday_r    <= {5'h0, wb[2:0]};
        ADDR_MONTH:    mon_r     <= {3'h0, wb[4:0]};
        ADDR_YEAR:     year_r    <= wb;
        ADDR_AL_MIN:   al_min_r  <= {1'b0, wb[6:0]};
        ADDR_AL_HOUR:  al_hour_r <= {2'b00, wb[5:0]};
        ADDR_AL_DAY:   al_day_r  <= {2'b00, wb[5:0]};
        ADDR_AL_MONTH: al_mon_r  <= {3'h0, wb[4:0]};
        ADDR_AL_YEAR:  al_year_r <= wb;
        default:       ;
      endcase
    end
  end

  // ==========================================================
  // half-second timebase, kept across each single reset
  // battery-side cold start: only all three resets at once clear this state,
  // so each reset alone leaves the timebase and calendar side running
  assign cold_start = !aresetn && !por_resetn && !rtc_resetn;
  assign half_tick  = (half_cnt_r == HALF_CYC - 1);
  always_ff @(posedge aclk)
  begin
    if (cold_start)
    begin
      half_cnt_r <= '0;
      pulse_r    <= 1'b0;
      half_r     <= 1'b0;
    end
    else
    begin
      half_cnt_r <= half_tick ? '0 : half_cnt_r + 32'd1;
      pulse_r    <= half_tick;
      if (half_tick)
        half_r <= !half_r;
    end
  end
  assign half_second_pulse_out = half_r;

  // ==========================================================
  // control bits, flags and countdown
  assign cd_tick  = countdown_active_r && (tick_cnt_r == TICK_CYC - 1);
  assign cd_under = cd_tick && (cd_r == '0);
  assign match    = fmatch(alarm_en_r[0], al_min_r, min_r)
                 && fmatch(alarm_en_r[1], al_hour_r, hour_r)
                 && fmatch(alarm_en_r[2], al_day_r, day_r)
                 && fmatch(alarm_en_r[3], al_mon_r, mon_r)
                 && fmatch(alarm_en_r[4], al_year_r, year_r);
  assign al_en_rise = wr_ok && awaddr_r == ADDR_ALARM_EN && |(wb[4:0] & ~alarm_en_r);

  always_comb
  begin
    flags_nxt  = flags_r;
    go_nxt     = countdown_go_r;
    active_nxt = countdown_active_r;
    cd_nxt     = cd_r;
    if (wr_ok && awaddr_r == ADDR_IRQ_FLAGS)
      flags_nxt = flags_r & wb;
    if (wr_ok && awaddr_r == ADDR_CD_CTRL)
      go_nxt = wb[BIT_GO];
    if (go_nxt && !countdown_active_r)
    begin
      active_nxt = 1'b1;
      cd_nxt     = reload_r;
    end
    else if (cd_under)
    begin
      flags_nxt[BIT_F_CD] = 1'b1;
      if (countdown_periodic_r)
        cd_nxt = reload_r;
      else
      begin
        go_nxt     = 1'b0;
        active_nxt = 1'b0;
      end
    end
    else if (cd_tick)
      cd_nxt = cd_r - 1'b1;
    if (!go_nxt && countdown_active_r && !cd_under && countdown_periodic_r)
      active_nxt = 1'b0;
    if (match && |alarm_en_r || al_en_rise)
      flags_nxt[BIT_F_ALARM] = 1'b1;
    if (rewrite_keep_counting_r && half_seen_r == 2'd1 && pulse_r)
      flags_nxt[BIT_F_REWRITE] = 1'b1;
    if (recall_busy_r)
      flags_nxt[BIT_F_RECALL] = 1'b1;
  end

  // alarm flag kept across always-on reset, cleared by software or cold start
  always_ff @(posedge aclk)
  begin
    if (cold_start)
      alarm_flag_r <= 1'b0;
    else
      alarm_flag_r <= flags_nxt[BIT_F_ALARM];
  end
  assign flags_r = {other_flags_r[6:5], alarm_flag_r, other_flags_r[4:0]};

  always_ff @(posedge aclk)
  begin
    if (!aresetn || !por_resetn)
    begin
      other_flags_r                <= '0;
      irq_en_r                     <= RST_BYTE;
      alarm_en_r                   <= '0;
      rewrite_keep_counting_r      <= 1'b0;
      counter_recall_r             <= 1'b0;
      recall_busy_r                <= 1'b0;
      countdown_periodic_r         <= 1'b0;
      reload_r                     <= '0;
      half_seen_r                  <= '0;
    end
    else
    begin
      other_flags_r    <= {flags_nxt[7:6], flags_nxt[4:0]};
      recall_busy_r    <= counter_recall_r;
      counter_recall_r <= (wr_ok && awaddr_r == ADDR_XFER_CTRL) ? wb[BIT_RECALL] : 1'b0;
      if (wr_ok)
      begin
        unique case (awaddr_r)
          ADDR_IRQ_EN:     irq_en_r <= wb;
          ADDR_ALARM_EN:   alarm_en_r <= wb[4:0];
          ADDR_MAIN_CTRL:  rewrite_keep_counting_r <= wb[BIT_KEEP_CNT];
          ADDR_CD_CTRL:    countdown_periodic_r <= wb[BIT_PERIODIC];
          ADDR_RELOAD_LO:  reload_r[7:0]   <= wb;
          ADDR_RELOAD_MID: reload_r[15:8]  <= wb;
          ADDR_RELOAD_HI:  reload_r[17:16] <= wb[1:0];
          default:         ;
        endcase
      end
      // two pulses seen while keep-counting stays set
      if (!rewrite_keep_counting_r)
        half_seen_r <= '0;
      else if (pulse_r && half_seen_r != 2'd2)
        half_seen_r <= half_seen_r + 2'd1;
    end
  end

  // operate bit lives with the calendar, kept across each single reset
  always_ff @(posedge aclk)
  begin
    if (cold_start)
      rtc_operate_r <= 1'b0;
    else if (wr_ok && awaddr_r == ADDR_MAIN_CTRL)
      rtc_operate_r <= wb[BIT_OPERATE];
  end

  // timer prescaler: cleared by power-on and system resets and while the countdown is idle, so rtc reset clears it a cycle later
  always_ff @(posedge aclk)
  begin
    if (!aresetn || !por_resetn || !countdown_active_r)
      tick_cnt_r <= '0;
    else
      tick_cnt_r <= (tick_cnt_r == TICK_CYC - 1) ? '0 : tick_cnt_r + 32'd1;
  end

  // timer counter: cleared by all three resets
  always_ff @(posedge aclk)
  begin
    if (!aresetn || !por_resetn || !rtc_resetn)
    begin
      cd_r               <= '0;
      countdown_go_r     <= 1'b0;
      countdown_active_r <= 1'b0;
    end
    else
    begin
      cd_r               <= cd_nxt;
      countdown_go_r     <= go_nxt;
      countdown_active_r <= active_nxt;
    end
  end

  assign irq = |(flags_r & irq_en_r);

  // ==========================================================
  // checks
  property p_oneshot_stop;
    @(posedge aclk) disable iff (!aresetn || !por_resetn || !rtc_resetn)
      (cd_under && !countdown_periodic_r && !(wr_ok && awaddr_r == ADDR_CD_CTRL))
      |=> !countdown_active_r && !countdown_go_r && flags_r[BIT_F_CD];
  endproperty
  a_oneshot_stop: assert property (p_oneshot_stop) else $error("one-shot did not stop");

  property p_periodic_reload;
    @(posedge aclk) disable iff (!aresetn || !por_resetn || !rtc_resetn)
      (cd_under && countdown_periodic_r && countdown_go_r)
      |=> countdown_active_r && cd_r == $past(reload_r);
  endproperty
  a_periodic_reload: assert property (p_periodic_reload) else $error("no reload");

  property p_irq;
    @(posedge aclk) disable iff (!aresetn || !por_resetn)
      cd_under |=> flags_r[BIT_F_CD] && (irq || !irq_en_r[BIT_F_CD]);
  endproperty
  a_irq: assert property (p_irq) else $error("irq mismatch");

  property p_alarm;
    @(posedge aclk) disable iff (!aresetn)
      (match && |alarm_en_r) |=> flags_r[BIT_F_ALARM];
  endproperty
  a_alarm: assert property (p_alarm) else $error("alarm flag missed");

  // recall bit drops one cycle after it is set, the done flag one cycle later
  sequence s_recall_done;
    !counter_recall_r ##1 flags_r[BIT_F_RECALL];
  endsequence

  property p_recall;
    @(posedge aclk) disable iff (!aresetn || !por_resetn)
      $rose(counter_recall_r) |=> s_recall_done;
  endproperty
  a_recall: assert property (p_recall) else $error("recall not completed");

  property p_start;
    @(posedge aclk) disable iff (!aresetn || !por_resetn || !rtc_resetn)
      (wr_ok && awaddr_r == ADDR_CD_CTRL && wb[BIT_GO] && !countdown_active_r)
      |=> countdown_active_r && cd_r == $past(reload_r);
  endproperty
  a_start: assert property (p_start) else $error("start did not load");

  property p_pin;
    @(posedge aclk) disable iff (cold_start)
      half_tick |=> half_second_pulse_out != $past(half_second_pulse_out);
  endproperty
  a_pin: assert property (p_pin) else $error("pin did not toggle");

  property p_en_rise;
    @(posedge aclk) disable iff (!aresetn)
      al_en_rise |=> flags_r[BIT_F_ALARM];
  endproperty
  a_en_rise: assert property (p_en_rise) else $error("enable did not flag");
endmodule

/* File: logic/rtc_count_pkg.sv */
package rtc_count_pkg;
  // ==========================================================
  // register byte addresses (word aligned)
  localparam logic [7:0] ADDR_MAIN_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_ALARM_EN    = 8'h04;
  localparam logic [7:0] ADDR_IRQ_FLAGS   = 8'h08;
  localparam logic [7:0] ADDR_IRQ_EN      = 8'h0c;
  localparam logic [7:0] ADDR_XFER_CTRL   = 8'h10;
  localparam logic [7:0] ADDR_CD_CTRL     = 8'h14;
  localparam logic [7:0] ADDR_SEC         = 8'h18;
  localparam logic [7:0] ADDR_MIN         = 8'h1c;
  localparam logic [7:0] ADDR_HOUR        = 8'h20;
  localparam logic [7:0] ADDR_DAY         = 8'h24;
  localparam logic [7:0] ADDR_WDAY        = 8'h28;
  localparam logic [7:0] ADDR_MONTH       = 8'h2c;
  localparam logic [7:0] ADDR_YEAR        = 8'h30;
  localparam logic [7:0] ADDR_AL_MIN      = 8'h34;
  localparam logic [7:0] ADDR_AL_HOUR     = 8'h38;
  localparam logic [7:0] ADDR_AL_DAY      = 8'h3c;
  localparam logic [7:0] ADDR_AL_MONTH    = 8'h40;
  localparam logic [7:0] ADDR_AL_YEAR     = 8'h44;
  localparam logic [7:0] ADDR_RELOAD_LO   = 8'h48;
  localparam logic [7:0] ADDR_RELOAD_MID  = 8'h4c;
  localparam logic [7:0] ADDR_RELOAD_HI   = 8'h50;
  // ==========================================================
  // field positions
  localparam int BIT_OPERATE    = 0;
  localparam int BIT_ACTIVE     = 2;
  localparam int BIT_KEEP_CNT   = 4;
  localparam int BIT_COPYING    = 7;
  localparam int BIT_RECALL     = 0;
  localparam int BIT_SAVE       = 1;
  localparam int BIT_GO         = 0;
  localparam int BIT_PERIODIC   = 1;
  localparam int BIT_CD_ACTIVE  = 2;
  localparam int BIT_F_CD       = 4;
  localparam int BIT_F_ALARM    = 5;
  localparam int BIT_F_REWRITE  = 6;
  localparam int BIT_F_RECALL   = 7;
  localparam int CD_WIDTH       = 18;
  // ==========================================================
  // reset values and timing
  localparam logic [7:0]  RST_BYTE       = 8'h00;
  localparam logic [1:0]  AXI_OKAY       = 2'b00;
  localparam logic [1:0]  AXI_SLVERR     = 2'b10;
  localparam int          CLK_HZ         = 25000000;
  localparam int          HALF_SEC_MS    = 500;
  localparam int          HALF_SEC_CYC   = CLK_HZ / 1000 * HALF_SEC_MS;
  localparam int          CD_TICK_CYC    = CLK_HZ;
endpackage

/* File: verif/tb_rtc_count.sv */
`timescale 1ns/10ps
module tb_rtc_count;
  import rtc_count_pkg::*;
  // ==========================================================
  // shortened counts keep the run to a few hundred cycles
  localparam int HC    = 4;
  localparam int TC    = 3;
  localparam int LIMIT = 20000;
  typedef struct {logic [31:0] d; logic [31:0] m; logic [1:0] r;} exp_t;
  logic        aclk;
  logic        aresetn;
  logic        por_resetn;
  logic        rtc_resetn;
  logic [7:0]  s_awaddr;
  logic        s_awvalid;
  logic        s_awready;
  logic [31:0] s_wdata;
  logic [3:0]  s_wstrb;
  logic        s_wvalid;
  logic        s_wready;
  logic [1:0]  s_bresp;
  logic        s_bvalid;
  logic        s_bready;
  logic [7:0]  s_araddr;
  logic        s_arvalid;
  logic        s_arready;
  logic [31:0] s_rdata;
  logic [1:0]  s_rresp;
  logic        s_rvalid;
  logic        s_rready;
  logic        half_second_pulse_out;
  logic        irq;
  int          fail_count;
  int          checks_done;
  int          cyc = 0;
  int          seed;
  logic [31:0] rv;
  exp_t        rq[$];
  logic [1:0]  bq[$];

  rtc_count #(.HALF_CYC(HC), .TICK_CYC(TC)) DUT (.aclk(aclk), .aresetn(aresetn),
    .por_resetn(por_resetn), .rtc_resetn(rtc_resetn), .s_awaddr(s_awaddr),
    .s_awvalid(s_awvalid), .s_awready(s_awready), .s_wdata(s_wdata), .s_wstrb(s_wstrb),
    .s_wvalid(s_wvalid), .s_wready(s_wready), .s_bresp(s_bresp), .s_bvalid(s_bvalid),
    .s_bready(s_bready), .s_araddr(s_araddr), .s_arvalid(s_arvalid),
    .s_arready(s_arready), .s_rdata(s_rdata), .s_rresp(s_rresp), .s_rvalid(s_rvalid),
    .s_rready(s_rready), .half_second_pulse_out(half_second_pulse_out), .irq(irq));

  // ==========================================================
  // clock, 25 MHz
  initial aclk = 1'b0;
  always #20 aclk = ~aclk;

  task final_report;
  begin
    $display("comparisons %0d, mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  end
  endtask

  task err(input string s);
  begin
    fail_count++;
    $display("[ERR] %0t %s", $time, s);
  end
  endtask

  // hang guard: a stuck handshake ends the run as a mismatch
  always @(posedge aclk)
  begin
    cyc <= cyc + 1;
    if (cyc == LIMIT)
    begin
      err("timeout");
      final_report;
    end
  end

  // ==========================================================
  // response watcher: oldest note against each answer
  always @(posedge aclk)
  begin
    if (s_rvalid === 1'b1 && s_rready === 1'b1)
    begin
      checks_done++;
      if (rq.size() == 0)
        err("unexpected read answer");
      else if (((s_rdata & rq[0].m) !== rq[0].d) || (s_rresp !== rq[0].r))
        err($sformatf("read %h resp %b, want %h", s_rdata, s_rresp, rq[0].d));
      if (rq.size() != 0)
        void'(rq.pop_front());
    end
    if (s_bvalid === 1'b1 && s_bready === 1'b1)
    begin
      checks_done++;
      if (bq.size() == 0 || s_bresp !== bq[0])
        err("write response mismatch");
      if (bq.size() != 0)
        void'(bq.pop_front());
    end
  end

  // ==========================================================
  // bus tasks: called just after a rising edge, release on the taking edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] r = AXI_OKAY);
    logic aw_ok;
    logic w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    bq.push_back(r);
    s_awaddr <= a;
    s_wdata <= {24'h000000, d};
    s_awvalid <= 1'b1;
    s_wvalid <= 1'b1;
    s_bready <= 1'b1;
    while (!(aw_ok && w_ok))
    begin
      @(posedge aclk);
      if (s_awvalid && s_awready === 1'b1)
      begin
        aw_ok = 1'b1;
        s_awvalid <= 1'b0;
      end
      if (s_wvalid && s_wready === 1'b1)
      begin
        w_ok = 1'b1;
        s_wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (s_bvalid !== 1'b1);
    s_bready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] d, input logic [7:0] m,
                    input logic [1:0] r = AXI_OKAY);
    exp_t e;
    e.d = {24'h000000, d & m};
    e.m = {24'h000000, m};
    e.r = r;
    rq.push_back(e);
    s_araddr <= a;
    s_arvalid <= 1'b1;
    s_rready <= 1'b1;
    do @(posedge aclk); while (s_arready !== 1'b1);
    s_arvalid <= 1'b0;
    while (s_rvalid !== 1'b1)
      @(posedge aclk);
    s_rready <= 1'b0;
    @(posedge aclk);
  endtask

  task chk(input logic v, input logic e, input string s);
  begin
    checks_done++;
    if (v !== e)
      err(s);
  end
  endtask

  // waits a bounded number of cycles for the request line
  task automatic wait_irq(input int n);
    int i;
    for (i = 0; i < n && irq !== 1'b1; i++)
      @(posedge aclk);
    chk(irq, 1'b1, "request never rose");
  endtask

  // measures one level of the pin, edge to edge
  task automatic half_len;
    int n;
    logic p;
    p = half_second_pulse_out;
    while (half_second_pulse_out === p)
      @(posedge aclk);
    p = half_second_pulse_out;
    n = 0;
    while (half_second_pulse_out === p)
    begin
      @(posedge aclk);
      n++;
    end
    checks_done++;
    if (n != HC)
      err($sformatf("pin level lasted %0d cycles", n));
  endtask

  // ==========================================================
  // main sequence
  initial
  begin
    {aresetn, por_resetn, rtc_resetn, s_awvalid, s_wvalid, s_bready} = '0;
    {s_arvalid, s_rready, s_awaddr, s_araddr, s_wdata} = '0;
    s_wstrb = 4'hf;
    fail_count = 0;
    checks_done = 0;
    seed = 5;
    repeat (5) @(posedge aclk);
    {aresetn, por_resetn, rtc_resetn} <= 3'b111;
    @(posedge aclk);
    rd(ADDR_IRQ_EN, 8'h00, 8'hff);
    rd(ADDR_CD_CTRL, 8'h00, 8'h07);
    rv = $random(seed);
    rd(8'h54 + (rv[7:0] & 8'h28), 8'h00, 8'hff, AXI_SLVERR);
    wr(8'h80 | (rv[7:0] & 8'h3c), rv[15:8], AXI_SLVERR);
    // random reload spread over three bytes, top byte keeps two bits
    rv = $random(seed);
    wr(ADDR_RELOAD_LO, rv[7:0]);
    wr(ADDR_RELOAD_MID, rv[15:8]);
    wr(ADDR_RELOAD_HI, rv[23:16]);
    rd(ADDR_RELOAD_LO, rv[7:0], 8'hff);
    rd(ADDR_RELOAD_MID, rv[15:8], 8'hff);
    rd(ADDR_RELOAD_HI, {6'h00, rv[17:16]}, 8'hff);
    // calendar one minute off the alarm; the minute is rewritten to match later
    wr(ADDR_MAIN_CTRL, 8'h01);
    wr(ADDR_MIN, 8'h29);
    wr(ADDR_HOUR, 8'h12);
    wr(ADDR_DAY, 8'h15);
    wr(ADDR_MONTH, 8'h06);
    wr(ADDR_YEAR, 8'h24);
    wr(ADDR_SEC, 8'h40);
    wr(ADDR_AL_MIN, 8'h30);
    wr(ADDR_AL_HOUR, 8'h12);
    wr(ADDR_AL_DAY, 8'h15);
    wr(ADDR_AL_MONTH, 8'h06);
    wr(ADDR_AL_YEAR, 8'h24);
    wr(ADDR_IRQ_FLAGS, 8'h00);
    wr(ADDR_IRQ_EN, 8'h20);
    wr(ADDR_ALARM_EN, 8'h1f);
    rd(ADDR_ALARM_EN, 8'h1f, 8'hff);
    rd(ADDR_IRQ_FLAGS, 8'h20, 8'h20);
    wr(ADDR_IRQ_FLAGS, 8'h00);
    rd(ADDR_IRQ_FLAGS, 8'h00, 8'h20);
    wr(ADDR_MIN, 8'h30);
    wait_irq(400);
    rd(ADDR_IRQ_FLAGS, 8'h20, 8'h20);
    rd(ADDR_MIN, 8'h30, 8'hff);
    wr(ADDR_IRQ_EN, 8'h00);
    chk(irq, 1'b0, "request with enable off");
    // one-shot countdown
    wr(ADDR_IRQ_FLAGS, 8'h00);
    wr(ADDR_IRQ_EN, 8'h10);
    wr(ADDR_RELOAD_LO, 8'h08);
    wr(ADDR_RELOAD_MID, 8'h00);
    wr(ADDR_RELOAD_HI, 8'h00);
    wr(ADDR_CD_CTRL, 8'h01);
    rd(ADDR_CD_CTRL, 8'h05, 8'h07);
    wait_irq(200);
    rd(ADDR_CD_CTRL, 8'h00, 8'h07);
    // periodic countdown, reload after each completion
    wr(ADDR_IRQ_FLAGS, 8'h00);
    wr(ADDR_CD_CTRL, 8'h02);
    wr(ADDR_CD_CTRL, 8'h03);
    wait_irq(200);
    wr(ADDR_IRQ_FLAGS, 8'h00);
    rd(ADDR_CD_CTRL, 8'h07, 8'h07);
    wait_irq(200);
    wr(ADDR_CD_CTRL, 8'h02);
    repeat (2) @(posedge aclk);
    rd(ADDR_CD_CTRL, 8'h02, 8'h07);
    wr(ADDR_IRQ_EN, 8'h00);
    chk(irq, 1'b0, "request with enable off");
    rd(ADDR_IRQ_FLAGS, 8'h10, 8'h10);
    half_len;
    half_len;
    // keep-counting held across two half-second pulses
    wr(ADDR_IRQ_FLAGS, 8'h00);
    wr(ADDR_MAIN_CTRL, 8'h11);
    repeat (3 * HC) @(posedge aclk);
    rd(ADDR_IRQ_FLAGS, 8'h40, 8'h40);
    wr(ADDR_MAIN_CTRL, 8'h01);
    // recall request clears itself and flags completion
    wr(ADDR_XFER_CTRL, 8'h01);
    repeat (2) @(posedge aclk);
    rd(ADDR_XFER_CTRL, 8'h00, 8'h01);
    rd(ADDR_IRQ_FLAGS, 8'h80, 8'h80);
    // three reset kinds against a running countdown
    wr(ADDR_RELOAD_LO, 8'h5a);
    wr(ADDR_CD_CTRL, 8'h01);
    rtc_resetn <= 1'b0;
    repeat (2) @(posedge aclk);
    rtc_resetn <= 1'b1;
    @(posedge aclk);
    rd(ADDR_CD_CTRL, 8'h00, 8'h07);
    rd(ADDR_RELOAD_LO, 8'h5a, 8'hff);
    rd(ADDR_HOUR, 8'h12, 8'hff);
    wr(ADDR_CD_CTRL, 8'h01);
    por_resetn <= 1'b0;
    repeat (2) @(posedge aclk);
    por_resetn <= 1'b1;
    @(posedge aclk);
    rd(ADDR_CD_CTRL, 8'h00, 8'h07);
    rd(ADDR_RELOAD_LO, 8'h00, 8'hff);
    rd(ADDR_HOUR, 8'h12, 8'hff);
    wr(ADDR_ALARM_EN, 8'h00);
    wr(ADDR_ALARM_EN, 8'h01);
    wr(ADDR_RELOAD_LO, 8'h5a);
    wr(ADDR_CD_CTRL, 8'h01);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(ADDR_CD_CTRL, 8'h00, 8'h07);
    rd(ADDR_YEAR, 8'h24, 8'hff);
    rd(ADDR_IRQ_FLAGS, 8'h20, 8'h20);
    rd(ADDR_MAIN_CTRL, 8'h05, 8'h05);
    final_report;
  end
endmodule
